// ### inc/pwr_consts.svh
// Offsets, field positions, reset values and timing counts of the power block
`ifndef PWR_CONSTS_SVH
`define PWR_CONSTS_SVH
`define MODE_CTRL_INDEX 8'h09
`define ADDR_MODE_CTRL 12'h024
`define ADDR_INT_STATUS 12'h040
`define ADDR_INT_MASK 12'h044
`define ADDR_CMD 12'h048
`define ADDR_STATE 12'h04C
`define BIT_GATE 2
`define BIT_DET_EN 3
`define BIT_DET_FLAG 5
`define MODE_RESET 8'h00
`define UNUSED_READ 8'h00
`define CMD_HALT 0
`define IRQ_DROOP 0
`define IRQ_WAKE 1
`define IRQ_SETTLED 2
`define IRQ_WIDTH 3
`define SETTLE_CYCLES 1024
`define PERSIST_TIME_US 1000
`define SLOW_OSC_HZ 12000
`define CLK_MHZ 250
`define SLOW_DIV (`CLK_MHZ * 1000000 / `SLOW_OSC_HZ)
`define PERSIST_TICKS ((`PERSIST_TIME_US * `SLOW_OSC_HZ + 999999) / 1000000)
`endif

// ### inc/pwr_pkg.sv
// Types shared by the power block
package pwr_pkg;
    typedef enum logic [1:0] {
        modeNormal,
        modeIdle,
        modeHalt
    } pmode_t;
    typedef enum logic [1:0] {
        stReset,
        stSettle,
        stRun,
        stSleep
    } seq_t;
endpackage

// ### inc/droop_if.sv
// Carrier between the droop filter and the top
interface droop_if;
    logic enable;
    logic lowSync;
    logic slowTick;
    logic droopReset;
    modport filter (input enable, input slowTick, input lowSync, output droopReset);
    modport ctrl (output enable, output slowTick, output lowSync, input droopReset);
endinterface

// ### design/droop_filter.sv
// Persistence filter that turns a long low-supply episode into a reset
`include "pwr_consts.svh"
module droop_filter (
    input wire logic clk,
    input wire logic rst_n,
    droop_if.filter dif
);
    logic [15:0] persistCnt_reg;

    // Count slow ticks while low persists; any recovery clears it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            persistCnt_reg <= 16'h0000;
        end else if (!dif.enable || !dif.lowSync) begin
            persistCnt_reg <= 16'h0000;
        end else if (dif.slowTick && persistCnt_reg <= 16'(`PERSIST_TICKS)) begin
            persistCnt_reg <= persistCnt_reg + 16'h0001;
        end
    end

    // Strictly longer than the interval before firing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dif.droopReset <= 1'b0;
        end else begin
            dif.droopReset <= persistCnt_reg > 16'(`PERSIST_TICKS);
        end
    end
endmodule

// ### design/slow_osc.sv
// Divider standing in for the internal slow oscillator
`include "pwr_consts.svh"
module slow_osc (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic tick
);
    logic [15:0] divCnt_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_reg <= 16'h0000;
            tick <= 1'b0;
        end else if (!run) begin
            divCnt_reg <= 16'h0000;
            tick <= 1'b0;
        end else if (divCnt_reg == 16'(`SLOW_DIV - 1)) begin
            divCnt_reg <= 16'h0000;
            tick <= 1'b1;
        end else begin
            divCnt_reg <= divCnt_reg + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule

// ### design/power_sequencer.sv
// Supply droop supervision, reset sequencing and power modes
// Functional notes
// - Droop reset and droop detector exist only when their option inputs select them.
// - Control bit 3 switches the droop detector on or off.
// - Control bit 5 is a read-only flag showing low supply.
// - Control bits 0, 1, 4, 6, 7 are unused and read with no defined value; this block reads them as 0.
// - With bit 2 clear, halt keeps the slow clock and its oscillator running (Idle).
// - With bit 2 set, halt gates the slow clock; its oscillator runs only with watchdog on.
// - Normal, Idle and HALT modes; halt stops the main oscillator and system clock.
// - The slow oscillator stays off unless the watchdog oscillator enable is set.
// - A droop reset acts exactly like the external clear pin.
// - In power-down both droop reset and droop detector are disabled.
// - A droop reset fires only after low supply persists longer than 1 ms.
// - Chip reset is the OR of droop reset and the external clear pin.
// - After reset, 1024 system clocks elapse before normal execution.
// - A falling edge on a wake-enabled port A pin wakes from power-down.
`include "pwr_consts.svh"
module power_sequencer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic droopResetOption,
    input wire logic droopDetectOption,
    input wire logic watchdogEnable,
    input wire logic watchdogOscEnable,
    input wire logic externalClearPin_n,
    input wire logic supplyLowAsync,
    input wire logic [7:0] portAPins,
    input wire logic [7:0] wakeOption,
    output logic chipReset,
    output logic cpuRun,
    output logic mainOscOn,
    output logic sysClockOn,
    output logic slowClockOn,
    output logic slowOscOn,
    output pwr_pkg::pmode_t powerMode,
    output logic irq
);
    import pwr_pkg::*;

    function automatic logic isAddr(input logic [11:0] a, input logic [11:0] ref_a);
        return a == ref_a;
    endfunction

    droop_if dif ();

    logic lowMeta_reg;
    logic lowSync_reg;
    logic lowPrev_reg;
    logic gateBit_reg;
    logic detEnBit_reg;
    logic [`IRQ_WIDTH-1:0] intStatus_reg;
    logic [`IRQ_WIDTH-1:0] intMask_reg;
    logic [`IRQ_WIDTH-1:0] events;
    logic [7:0] portPrev_reg;
    logic [10:0] settleCnt_reg;
    seq_t seq_reg;
    logic sleeping;
    logic wake;
    logic droopReq;
    logic resetReq;
    logic detectActive;
    logic slowRun;
    logic slowTick;
    logic wrEn;
    logic rdEn;
    logic haltCmd;
    logic settleDone;
    logic [7:0] modeRead;

    // Comparator output is asynchronous to clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowMeta_reg <= 1'b0;
            lowSync_reg <= 1'b0;
            lowPrev_reg <= 1'b0;
        end else begin
            lowMeta_reg <= supplyLowAsync;
            lowSync_reg <= lowMeta_reg;
            lowPrev_reg <= lowSync_reg;
        end
    end

    assign sleeping = (seq_reg == stSleep);
    assign detectActive = droopDetectOption && detEnBit_reg && !sleeping;

    // Slow oscillator runs only with its enable, and only as halt mode allows
    assign slowRun = watchdogOscEnable
        && (!sleeping || !gateBit_reg || watchdogEnable);

    slow_osc slowOsc (
        .clk(clk),
        .rst_n(rst_n),
        .run(slowRun),
        .tick(slowTick)
    );

    assign dif.enable = droopResetOption && !sleeping;
    assign dif.lowSync = lowSync_reg;
    assign dif.slowTick = slowTick;

    droop_filter droopFilter (
        .clk(clk),
        .rst_n(rst_n),
        .dif(dif)
    );

    assign droopReq = dif.droopReset;
    assign resetReq = droopReq || !externalClearPin_n;

    // APB decode; zero-wait slave
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && !penable && !pwrite;
    assign haltCmd = wrEn && isAddr(paddr, `ADDR_CMD) && pwdata[`CMD_HALT] && seq_reg == stRun;

    // Unused bits have no defined value; they are driven as a fixed pattern
    always_comb begin
        modeRead = `UNUSED_READ;
        modeRead[`BIT_GATE] = gateBit_reg;
        modeRead[`BIT_DET_EN] = detEnBit_reg;
        modeRead[`BIT_DET_FLAG] = detectActive && lowSync_reg;
    end

    // Control bits; reset by the internal chip reset as well
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gateBit_reg <= 1'b0;
            detEnBit_reg <= 1'b0;
        end else if (resetReq) begin
            gateBit_reg <= 1'b0;
            detEnBit_reg <= 1'b0;
        end else if (wrEn && isAddr(paddr, `ADDR_MODE_CTRL)) begin
            gateBit_reg <= pwdata[`BIT_GATE];
            detEnBit_reg <= pwdata[`BIT_DET_EN];
        end
    end

    // Wake on falling edge of enabled port A pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portPrev_reg <= 8'hFF;
        end else begin
            portPrev_reg <= portAPins;
        end
    end
    assign wake = |(portPrev_reg & ~portAPins & wakeOption);

    assign settleDone = (settleCnt_reg == 11'(`SETTLE_CYCLES - 1));

    // Reset, settle, run and sleep sequence
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_reg <= stReset;
            settleCnt_reg <= 11'h000;
        end else if (resetReq) begin
            seq_reg <= stReset;
            settleCnt_reg <= 11'h000;
        end else begin
            case (seq_reg)
                stReset: begin
                    seq_reg <= stSettle;
                    settleCnt_reg <= 11'h000;
                end
                stSettle: begin
                    if (settleDone) begin
                        seq_reg <= stRun;
                    end else begin
                        settleCnt_reg <= settleCnt_reg + 11'h001;
                    end
                end
                stRun: begin
                    if (haltCmd) begin
                        seq_reg <= stSleep;
                    end
                end
                default: begin
                    if (wake) begin
                        seq_reg <= stSettle;
                        settleCnt_reg <= 11'h000;
                    end
                end
            endcase
        end
    end

    // Onset of low supply; only the synchronised copy is used
    assign events[`IRQ_DROOP] = detectActive && lowSync_reg && !lowPrev_reg;
    assign events[`IRQ_WAKE] = sleeping && wake;
    assign events[`IRQ_SETTLED] = (seq_reg == stSettle) && settleDone;

    // Sticky status; a new event wins over a write-one clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intStatus_reg <= '0;
            intMask_reg <= '0;
        end else begin
            if (wrEn && isAddr(paddr, `ADDR_INT_STATUS)) begin
                intStatus_reg <= (intStatus_reg & ~pwdata[`IRQ_WIDTH-1:0]) | events;
            end else begin
                intStatus_reg <= intStatus_reg | events;
            end
            if (wrEn && isAddr(paddr, `ADDR_INT_MASK)) begin
                intMask_reg <= pwdata[`IRQ_WIDTH-1:0];
            end
        end
    end

    // Read data registered in setup phase so it is valid in access phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pslverr <= !(isAddr(paddr, `ADDR_MODE_CTRL) || isAddr(paddr, `ADDR_INT_STATUS)
                    || isAddr(paddr, `ADDR_INT_MASK) || isAddr(paddr, `ADDR_CMD)
                    || isAddr(paddr, `ADDR_STATE));
            end
            if (rdEn) begin
                if (isAddr(paddr, `ADDR_MODE_CTRL)) begin
                    prdata <= {24'h00_0000, modeRead};
                end else if (isAddr(paddr, `ADDR_INT_STATUS)) begin
                    prdata <= {29'h0, intStatus_reg};
                end else if (isAddr(paddr, `ADDR_INT_MASK)) begin
                    prdata <= {29'h0, intMask_reg};
                end else if (isAddr(paddr, `ADDR_STATE)) begin
                    prdata <= {28'h000_0000, powerMode, seq_reg};
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chipReset <= 1'b1;
            cpuRun <= 1'b0;
            mainOscOn <= 1'b1;
            sysClockOn <= 1'b1;
            slowClockOn <= 1'b0;
            slowOscOn <= 1'b0;
            powerMode <= modeNormal;
            irq <= 1'b0;
        end else begin
            chipReset <= resetReq || seq_reg == stReset;
            cpuRun <= seq_reg == stRun;
            mainOscOn <= !sleeping;
            sysClockOn <= !sleeping;
            slowClockOn <= watchdogOscEnable && !(sleeping && gateBit_reg);
            slowOscOn <= slowRun;
            powerMode <= !sleeping ? modeNormal : (gateBit_reg ? modeHalt : modeIdle);
            irq <= |(intStatus_reg & intMask_reg);
        end
    end
endmodule

// ### verification/power_sequencer_chk.sv
// Port-level checker for the power sequencer
`include "pwr_consts.svh"
module power_sequencer_chk
    import pwr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic droopDetectOption,
    input wire logic watchdogOscEnable,
    input wire logic externalClearPin_n,
    input wire logic supplyLowAsync,
    input wire logic chipReset,
    input wire logic cpuRun,
    input wire logic mainOscOn,
    input wire logic sysClockOn,
    input wire logic slowClockOn,
    input wire logic slowOscOn,
    input wire pwr_pkg::pmode_t powerMode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [19:0] lowCnt;
    logic [3:0] clrAge;
    logic [11:0] idleCnt;
    logic ctrlRead;
    assign ctrlRead = psel && !penable && !pwrite && paddr == `ADDR_MODE_CTRL;
    // Saturating ages; a wrap would make a long droop look short
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt <= '0;
            clrAge <= 4'hF;
            idleCnt <= '0;
        end else begin
            lowCnt <= !supplyLowAsync ? '0 : lowCnt + 20'(lowCnt != '1);
            clrAge <= !externalClearPin_n ? '0 : clrAge + 4'(clrAge != 4'hF);
            idleCnt <= cpuRun ? '0 : idleCnt + 12'(idleCnt != '1);
        end
    end
    property p_clr; !externalClearPin_n |-> ##[1:4] chipReset; endproperty
    a_clr: assert property (p_clr) else $error("clear pin ignored");
    property p_settle; $rose(cpuRun) |-> idleCnt >= 12'd1023; endproperty
    a_settle: assert property (p_settle) else $error("settle too short");
    property p_run; cpuRun |-> sysClockOn && mainOscOn && powerMode == modeNormal; endproperty
    a_run: assert property (p_run) else $error("run without clocks");
    property p_halt; powerMode == modeHalt |-> !slowClockOn && !sysClockOn; endproperty
    a_halt: assert property (p_halt) else $error("halt clocks on");
    property p_oscOff; !watchdogOscEnable [*2] |-> !slowOscOn; endproperty
    a_oscOff: assert property (p_oscOff) else $error("slow osc on");
    property p_noDet; ctrlRead && !droopDetectOption |=> !prdata[5]; endproperty
    a_noDet: assert property (p_noDet) else $error("flag without option");
    property p_unused; ctrlRead |=> prdata[1:0] == 2'h0 && !prdata[4] && prdata[7:6] == 2'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bits set");
    property p_sleep; externalClearPin_n [*6] ##0 powerMode != modeNormal |=> !chipReset;
    endproperty
    a_sleep: assert property (p_sleep) else $error("reset in sleep");
    property p_long; $rose(chipReset) |-> clrAge < 4'h8 || lowCnt > 20'd250000; endproperty
    a_long: assert property (p_long) else $error("short droop reset");
    c_idle: cover property (powerMode == modeIdle);
    c_halt: cover property (powerMode == modeHalt);
    c_run: cover property ($rose(cpuRun));
endmodule
bind power_sequencer power_sequencer_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .droopDetectOption(droopDetectOption), .watchdogOscEnable(watchdogOscEnable),
    .externalClearPin_n(externalClearPin_n), .supplyLowAsync(supplyLowAsync),
    .chipReset(chipReset), .cpuRun(cpuRun), .mainOscOn(mainOscOn), .sysClockOn(sysClockOn),
    .slowClockOn(slowClockOn), .slowOscOn(slowOscOn), .powerMode(powerMode));

// ### verification/supply_model.sv
// Supply comparator and external clear pin beside the block
module supply_model (
    input wire logic lowReq,
    input wire logic clearReq,
    output logic supplyLowAsync,
    output logic externalClearPin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial supplyLowAsync = 1'h0;
    // Comparator is unclocked, so it moves off the clock edge
    always @(lowReq) supplyLowAsync <= #1.3 lowReq;
    assign externalClearPin_n = !clearReq;
endmodule

// ### verification/power_sequencer_bench.sv
// Self-checking bench for the power sequencer
`include "pwr_consts.svh"
module power_sequencer_bench import pwr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
    logic detOpt = 1'h1, wdEn = 1'h1, wdOscEn = 1'h1, lowReq = 1'h0, clearReq = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [7:0] pins = 8'hFF;
    logic pready, pslverr, irq, clearPin_n, supplyLow, chipReset, cpuRun;
    logic mainOscOn, sysClockOn, slowClockOn, slowOscOn;
    pmode_t powerMode;
    int bad_count, compares;
    power_sequencer u_power_sequencer (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .droopResetOption(1'h1), .droopDetectOption(detOpt),
        .watchdogEnable(wdEn), .watchdogOscEnable(wdOscEn), .externalClearPin_n(clearPin_n),
        .supplyLowAsync(supplyLow), .portAPins(pins), .wakeOption(8'h01), .chipReset(chipReset),
        .cpuRun(cpuRun), .mainOscOn(mainOscOn), .sysClockOn(sysClockOn),
        .slowClockOn(slowClockOn), .slowOscOn(slowOscOn), .powerMode(powerMode), .irq(irq));
    supply_model u_supply_model (.lowReq(lowReq), .clearReq(clearReq),
        .supplyLowAsync(supplyLow), .externalClearPin_n(clearPin_n));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic ck(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic xfer(logic [11:0] a, logic w, logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdCk(string what, logic [11:0] a, logic [31:0] exp);
        xfer(a, 1'h0, 32'h0000_0000);
        ck(what, rd, exp);
    endtask
    task automatic waitRun(string what);
        int n;
        n = 0;
        while (cpuRun !== 1'h1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        ck(what, 32'(n >= 1020 && n <= 1045), 32'h1);
    endtask
    task automatic nap(logic [31:0] ctrl, pmode_t mode, logic [1:0] slow);
        xfer(`ADDR_MODE_CTRL, 1'h1, ctrl);
        xfer(`ADDR_CMD, 1'h1, 32'h0000_0001);
        repeat (4) @(posedge clk);
        ck("mode", 32'(powerMode), 32'(mode));
        ck("clocks", {mainOscOn, sysClockOn, slowClockOn, slowOscOn}, {2'h0, slow});
        rdCk("state", `ADDR_STATE, 32'({mode, stSleep}));
        // Pin 1 has no wake option, so it must not wake
        pins <= 8'hFD;
        repeat (8) @(posedge clk);
        ck("no wake", 32'(cpuRun), 32'h0);
        pins <= 8'hFC;
        waitRun("wake");
        pins <= 8'hFF;
        rdCk("wake status", `ADDR_INT_STATUS, 32'h0000_0006);
        xfer(`ADDR_INT_STATUS, 1'h1, 32'h0000_0006);
    endtask
    task automatic conclude();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        ck("reset", 32'(chipReset), 32'h1);
        waitRun("settle");
        rdCk("ctrl rst", `ADDR_MODE_CTRL, 32'(`MODE_RESET));
        rdCk("state run", `ADDR_STATE, 32'({modeNormal, stRun}));
        rdCk("unmapped", 12'h0FC, 32'h0000_0000);
        ck("slverr", 32'(err), 32'h1);
        xfer(`ADDR_MODE_CTRL, 1'h1, 32'hFFFF_FFFF);
        rdCk("ctrl", `ADDR_MODE_CTRL, 32'h0000_000C);
        lowReq <= 1'h1;
        repeat (10) @(posedge clk);
        rdCk("flag", `ADDR_MODE_CTRL, 32'h0000_002C);
        xfer(`ADDR_MODE_CTRL, 1'h1, 32'h0000_0008);
        rdCk("flag ro", `ADDR_MODE_CTRL, 32'h0000_0028);
        lowReq <= 1'h0;
        repeat (10) @(posedge clk);
        rdCk("flag off", `ADDR_MODE_CTRL, 32'h0000_0008);
        ck("short droop", 32'(chipReset), 32'h0);
        rdCk("status", `ADDR_INT_STATUS, 32'h0000_0005);
        // Mask bit set means the source may raise the interrupt
        ck("irq masked", 32'(irq), 32'h0);
        xfer(`ADDR_INT_MASK, 1'h1, 32'h0000_0007);
        repeat (2) @(posedge clk);
        ck("irq", 32'(irq), 32'h1);
        xfer(`ADDR_INT_STATUS, 1'h1, 32'h0000_0007);
        repeat (2) @(posedge clk);
        ck("irq clr", 32'(irq), 32'h0);
        rdCk("status clr", `ADDR_INT_STATUS, 32'h0000_0000);
        xfer(`ADDR_INT_MASK, 1'h1, 32'h0000_0000);
        detOpt <= 1'h0;
        lowReq <= 1'h1;
        repeat (10) @(posedge clk);
        xfer(`ADDR_MODE_CTRL, 1'h0, 32'h0000_0000);
        ck("no det", rd & 32'h0000_0020, 32'h0000_0000);
        lowReq <= 1'h0;
        detOpt <= 1'h1;
        nap(32'h0000_0008, modeIdle, 2'h3);
        nap(32'h0000_000C, modeHalt, 2'h1);
        wdEn <= 1'h0;
        nap(32'h0000_000C, modeHalt, 2'h0);
        wdOscEn <= 1'h0;
        repeat (3) @(posedge clk);
        ck("osc off", 32'(slowOscOn), 32'h0);
        wdOscEn <= 1'h1;
        clearReq <= 1'h1;
        repeat (6) @(posedge clk);
        ck("clear", {cpuRun, chipReset}, 32'h1);
        clearReq <= 1'h0;
        waitRun("clear settle");
        rdCk("ctrl clr", `ADDR_MODE_CTRL, 32'h0000_0000);
        conclude();
    end
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule
